// ==== rtl/rxirq_defs.svh ====
`ifndef RXIRQ_DEFS_SVH
`define RXIRQ_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RXIRQ_ADDR_EVT_CLR 7'h42
`define RXIRQ_ADDR_EVT_FLG 7'h43
`define RXIRQ_ADDR_FIFO_ST 7'h44

// ----------------------------------------
// field positions
// ----------------------------------------
`define RXIRQ_BIT_SL_TMO 3'd7
`define RXIRQ_BIT_RX_TMO 3'd6
`define RXIRQ_BIT_STRENGTH 3'd5
`define RXIRQ_BIT_PREAMBLE 3'd4
`define RXIRQ_BIT_SYNC 3'd3
`define RXIRQ_BIT_NODE 3'd2
`define RXIRQ_BIT_CHECKSUM 3'd1
`define RXIRQ_BIT_PKT_DONE 3'd0
`define RXIRQ_BIT_Q_FULL 3'd6
`define RXIRQ_BIT_Q_NMTY 3'd5
`define RXIRQ_BIT_Q_TH 3'd4
`define RXIRQ_BIT_Q_OVF 3'd3
`define RXIRQ_BIT_Q_FLUSH 3'd2

// ----------------------------------------
// reset values
// ----------------------------------------
`define RXIRQ_FLAGS_RST 8'h00
`define RXIRQ_SEL_RST 4'h0

`endif

// ==== rtl/rxirq_flags.sv ====
// Functional notes
// - event clears act only in standby/tune/rx/nvm
// - sleep timeout sets bit 7 when enabled
// - write one bit 7 clears sleep flag
// - receive timeout sets bit 6 when enabled
// - write one bit 6 clears receive flag
// - strength valid sets bit 5 under fsk
// - write one bit 5 clears strength flag
// - preamble pass sets bit 4 when enabled
// - sync pass sets bit 3 when enabled
// - node match sets bit 2 in packet mode
// - checksum pass sets bit 1 in packet mode
// - packet done sets bit 0 in packet mode
// - bits 4..0 one clears matching flag
// - full status follows fifo full
// - not empty status follows byte count
// - threshold status when count reaches threshold
// - overflow status follows overflow condition
// - fifo status only in buffer/packet mode
// - flush bit acts only in active states
// - sleep state clears fifo and packet handler
// - disabled event never raises its flag
// - two selectors route events to outputs
// - byte written strobe pulses per stored byte
`include "rxirq_defs.svh"

module rxirq_flags #(
    parameter int CNT_W = 6
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire rxirq_pkg::rxirq_regreq_s reg_req,
    output logic [7:0] reg_rdata,
    input wire rxirq_pkg::rxirq_opstate_e op_state,
    input wire rxirq_pkg::rxirq_mode_e data_mode,
    input wire logic fsk_demod,
    input wire rxirq_pkg::rxirq_events_s events,
    input wire rxirq_pkg::rxirq_enables_s enables,
    input wire logic [3:0] irq_out_a_select,
    input wire logic [3:0] irq_out_b_select,
    input wire logic strength_indicator,
    input wire rxirq_pkg::rxirq_queue_s queue_in,
    input wire logic [CNT_W-1:0] queue_count,
    input wire logic [CNT_W-1:0] queue_threshold,
    output logic queue_flush,
    output logic packet_handler_reset,
    output logic irq_out_a,
    output logic irq_out_b
);
    import rxirq_pkg::*;

    // all checks run on the system clock and rest while reset is held
    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic active_state;
    logic clr_wr;
    logic fifo_wr;
    logic buf_mode;
    logic pkt_mode;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] flags_q;
    logic [7:0] fifo_stat;
    logic flush_q;
    localparam logic [7:0] FLAGS_RST = `RXIRQ_FLAGS_RST;

    // standby, tune, receive and nvm accept clear and flush writes
    assign active_state = (op_state == RXIRQ_ST_STBY) || (op_state == RXIRQ_ST_TUNE) ||
                          (op_state == RXIRQ_ST_RX) || (op_state == RXIRQ_ST_NVM);
    assign clr_wr = reg_req.wr_en && (reg_req.addr == `RXIRQ_ADDR_EVT_CLR) && active_state;
    assign fifo_wr = reg_req.wr_en && (reg_req.addr == `RXIRQ_ADDR_FIFO_ST);
    assign buf_mode = (data_mode == RXIRQ_MODE_BUFFER);
    assign pkt_mode = (data_mode == RXIRQ_MODE_PACKET);

    // ----------------------------------------
    // event flags
    // ----------------------------------------
    // qualify each event with its enable and the mode it belongs to
    always_comb begin
        set_vec = 8'h00;
        set_vec[`RXIRQ_BIT_SL_TMO] = events.sleep_timeout &&
                                     enables.sleep_timeout_enable;
        set_vec[`RXIRQ_BIT_RX_TMO] = events.receive_timeout &&
                                     enables.receive_timeout_enable;
        set_vec[`RXIRQ_BIT_STRENGTH] = events.strength_valid && fsk_demod &&
                                       enables.strength_valid_enable;
        set_vec[`RXIRQ_BIT_PREAMBLE] = events.preamble_pass &&
                                       enables.preamble_pass_enable;
        set_vec[`RXIRQ_BIT_SYNC] = events.sync_pass && enables.sync_pass_enable;
        set_vec[`RXIRQ_BIT_NODE] = events.node_match && pkt_mode &&
                                   enables.node_match_enable;
        set_vec[`RXIRQ_BIT_CHECKSUM] = events.checksum_pass && pkt_mode &&
                                       enables.checksum_pass_enable;
        set_vec[`RXIRQ_BIT_PKT_DONE] = events.packet_done && pkt_mode &&
                                       enables.packet_done_enable;
    end

    // a one in the clear register drops the matching flag, zero keeps it
    assign clr_vec = clr_wr ? reg_req.wdata : 8'h00;

    // sticky flags, one flop each; a set in the clearing cycle wins so no event is lost
    for (genvar i = 0; i < 8; i++) begin : g_flag
        always_ff @(posedge sys_clk) begin
            if (!rstn) begin
                flags_q[i] <= FLAGS_RST[i];
            end else if (set_vec[i]) begin
                flags_q[i] <= 1'b1;
            end else if (clr_vec[i]) begin
                flags_q[i] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // fifo status and flush
    // ----------------------------------------
    // live status, no storage: each bit follows its source condition
    always_comb begin
        fifo_stat = 8'h00;
        if (buf_mode || pkt_mode) begin
            fifo_stat[`RXIRQ_BIT_Q_FULL] = queue_in.queue_full;
            fifo_stat[`RXIRQ_BIT_Q_NMTY] = (queue_count != '0);
            fifo_stat[`RXIRQ_BIT_Q_TH] = (queue_count >= queue_threshold);
            fifo_stat[`RXIRQ_BIT_Q_OVF] = queue_in.queue_overflow;
        end
    end

    // flush pulse; sleep holds it so the queue stays empty while asleep
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= (fifo_wr && active_state &&
                        reg_req.wdata[`RXIRQ_BIT_Q_FLUSH]) ||
                       (op_state == RXIRQ_ST_SLEEP);
        end
    end
    assign queue_flush = flush_q;
    assign packet_handler_reset = (op_state == RXIRQ_ST_SLEEP);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // clear register is write only and reads zero; reserved bits read zero
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd_en) begin
            case (reg_req.addr)
                `RXIRQ_ADDR_EVT_FLG: reg_rdata <= flags_q;
                `RXIRQ_ADDR_FIFO_ST: reg_rdata <= fifo_stat;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // interrupt output routing
    // ----------------------------------------
    // code-to-source mapping differs per data mode; the byte strobe is live only
    function automatic logic route(input logic [3:0] sel, input rxirq_mode_e m,
                                   input logic [7:0] f, input logic [7:0] q,
                                   input logic wb, input logic ind);
        logic r;
        r = 1'b0;
        case (sel)
            4'h1: r = f[`RXIRQ_BIT_STRENGTH];
            4'h2: r = f[`RXIRQ_BIT_PREAMBLE];
            4'h3: r = f[`RXIRQ_BIT_SYNC];
            default: r = 1'b0;
        endcase
        if (m == RXIRQ_MODE_PACKET) begin
            case (sel)
                4'h4: r = f[`RXIRQ_BIT_NODE];
                4'h5: r = f[`RXIRQ_BIT_CHECKSUM];
                4'h6: r = f[`RXIRQ_BIT_PKT_DONE];
                4'h7: r = f[`RXIRQ_BIT_SL_TMO];
                4'h8: r = f[`RXIRQ_BIT_RX_TMO];
                4'h9: r = q[`RXIRQ_BIT_Q_NMTY];
                4'ha: r = q[`RXIRQ_BIT_Q_TH];
                4'hb: r = q[`RXIRQ_BIT_Q_FULL];
                4'hc: r = wb;
                4'hd: r = q[`RXIRQ_BIT_Q_OVF];
                4'he: r = ind;
                default: r = r;
            endcase
        end else begin
            case (sel)
                4'h4: r = f[`RXIRQ_BIT_SL_TMO];
                4'h5: r = f[`RXIRQ_BIT_RX_TMO];
                4'h6: r = (m == RXIRQ_MODE_DIRECT) ? ind : q[`RXIRQ_BIT_Q_NMTY];
                4'h7: r = (m == RXIRQ_MODE_BUFFER) && q[`RXIRQ_BIT_Q_TH];
                4'h8: r = (m == RXIRQ_MODE_BUFFER) && q[`RXIRQ_BIT_Q_FULL];
                4'h9: r = (m == RXIRQ_MODE_BUFFER) && wb;
                4'ha: r = (m == RXIRQ_MODE_BUFFER) && q[`RXIRQ_BIT_Q_OVF];
                4'hb: r = (m == RXIRQ_MODE_BUFFER) && ind;
                default: r = r;
            endcase
        end
        return r;
    endfunction

    // byte strobe passes straight through, never latched into a flag
    always_comb begin
        irq_out_a = route(irq_out_a_select, data_mode, flags_q, fifo_stat,
                          queue_in.queue_byte_written_pulse, strength_indicator);
        irq_out_b = route(irq_out_b_select, data_mode, flags_q, fifo_stat,
                          queue_in.queue_byte_written_pulse, strength_indicator);
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_clear_write(int b);
        clr_wr && reg_req.wdata[b];
    endsequence

    // a flush write in a state that accepts it
    sequence s_flush_write;
        fifo_wr && active_state && reg_req.wdata[`RXIRQ_BIT_Q_FLUSH];
    endsequence

    // a status read while the queue is in use
    sequence s_status_read;
        reg_req.rd_en && (reg_req.addr == `RXIRQ_ADDR_FIFO_ST) && (buf_mode || pkt_mode);
    endsequence

    a_sleep_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        events.sleep_timeout && enables.sleep_timeout_enable |=> flags_q[7])
        else $error("sleep flag not set");
    a_sleep_flag_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_clear_write(7) ##0 !set_vec[7] |=> !flags_q[7])
        else $error("sleep flag not cleared");
    a_rx_flag_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_clear_write(6) ##0 !set_vec[6] |=> !flags_q[6])
        else $error("receive flag not cleared");
    a_clear_gated_state: assert property (@(posedge sys_clk) disable iff (!rstn)
        !active_state && set_vec == 8'h00 |=> flags_q == $past(flags_q))
        else $error("flags changed outside active states");
    a_enable_blocks: assert property (@(posedge sys_clk) disable iff (!rstn)
        !flags_q[4] && !enables.preamble_pass_enable |=> !flags_q[4])
        else $error("disabled preamble flag rose");
    a_node_pkt_only: assert property (@(posedge sys_clk) disable iff (!rstn)
        !flags_q[2] && !pkt_mode |=> !flags_q[2])
        else $error("node flag outside packet mode");
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
        flags_q[0] && !clr_vec[0] |=> flags_q[0])
        else $error("packet done flag dropped");
    a_status_direct: assert property (@(posedge sys_clk) disable iff (!rstn)
        data_mode == RXIRQ_MODE_DIRECT |-> fifo_stat == 8'h00)
        else $error("fifo status in direct mode");
    a_flush_gated: assert property (@(posedge sys_clk) disable iff (!rstn)
        fifo_wr && !active_state && op_state != RXIRQ_ST_SLEEP |=> !queue_flush)
        else $error("flush outside active states");
    a_sleep_flush: assert property (@(posedge sys_clk) disable iff (!rstn)
        op_state == RXIRQ_ST_SLEEP |=> queue_flush)
        else $error("sleep did not flush");

    // ----------------------------------------
    // event flag checks
    // ----------------------------------------
    a_rx_flag_set: assert property (
        events.receive_timeout && enables.receive_timeout_enable |=> flags_q[6])
        else $error("receive flag not set");
    a_strength_set: assert property (
        events.strength_valid && fsk_demod && enables.strength_valid_enable |=> flags_q[5])
        else $error("strength flag not set");
    a_strength_no_fsk: assert property (
        !flags_q[5] && !fsk_demod |=> !flags_q[5])
        else $error("strength flag rose without fsk");
    a_strength_clr: assert property (
        s_clear_write(5) ##0 !set_vec[5] |=> !flags_q[5])
        else $error("strength flag not cleared");
    a_preamble_set: assert property (
        events.preamble_pass && enables.preamble_pass_enable |=> flags_q[4])
        else $error("preamble flag not set");
    a_sync_set: assert property (
        events.sync_pass && enables.sync_pass_enable |=> flags_q[3])
        else $error("sync flag not set");
    a_node_set: assert property (
        events.node_match && pkt_mode && enables.node_match_enable |=> flags_q[2])
        else $error("node flag not set");
    a_checksum_set: assert property (
        events.checksum_pass && pkt_mode && enables.checksum_pass_enable |=> flags_q[1])
        else $error("checksum flag not set");
    a_checksum_pkt: assert property (
        !flags_q[1] && !pkt_mode |=> !flags_q[1])
        else $error("checksum flag outside packet mode");
    a_done_set: assert property (
        events.packet_done && pkt_mode && enables.packet_done_enable |=> flags_q[0])
        else $error("packet done flag not set");
    a_done_pkt_only: assert property (
        !flags_q[0] && !pkt_mode |=> !flags_q[0])
        else $error("packet done flag outside packet mode");
    a_low_clr: assert property (
        s_clear_write(4) ##0 !set_vec[4] |=> !flags_q[4])
        else $error("preamble flag not cleared");
    a_clear_keeps: assert property (
        clr_wr && !reg_req.wdata[3] && flags_q[3] |=> flags_q[3])
        else $error("zero in clear write dropped a flag");
    a_set_wins: assert property (
        set_vec[7] ##0 s_clear_write(7) |=> flags_q[7])
        else $error("clear beat a same cycle set");
    a_clear_reads_zero: assert property (
        reg_req.rd_en && (reg_req.addr == `RXIRQ_ADDR_EVT_CLR) |=> reg_rdata == 8'h00)
        else $error("clear register read not zero");
    a_flags_read: assert property (
        reg_req.rd_en && (reg_req.addr == `RXIRQ_ADDR_EVT_FLG) |=> reg_rdata == $past(flags_q))
        else $error("flag read does not match flags");

    // ----------------------------------------
    // fifo status, flush and sleep checks
    // ----------------------------------------
    a_full_read: assert property (
        s_status_read |=> reg_rdata[6] == $past(queue_in.queue_full))
        else $error("full status read wrong");
    a_nmty_read: assert property (
        s_status_read |=> reg_rdata[5] == ($past(queue_count) != '0))
        else $error("not empty status read wrong");
    a_threshold_read: assert property (
        s_status_read |=> reg_rdata[4] == ($past(queue_count) >= $past(queue_threshold)))
        else $error("threshold status read wrong");
    a_overflow_read: assert property (
        s_status_read |=> reg_rdata[3] == $past(queue_in.queue_overflow))
        else $error("overflow status read wrong");
    a_direct_read: assert property (
        reg_req.rd_en && (reg_req.addr == `RXIRQ_ADDR_FIFO_ST) && !buf_mode && !pkt_mode |=>
        reg_rdata == 8'h00)
        else $error("status read not zero in direct mode");
    a_flush_pulse: assert property (
        s_flush_write |=> queue_flush)
        else $error("flush write gave no flush");
    a_flush_once: assert property (
        !(fifo_wr && reg_req.wdata[`RXIRQ_BIT_Q_FLUSH]) && (op_state != RXIRQ_ST_SLEEP) |=>
        !queue_flush)
        else $error("flush without a request");
    a_handler_reset: assert property (
        packet_handler_reset == (op_state == RXIRQ_ST_SLEEP))
        else $error("handler reset does not follow sleep");

    // ----------------------------------------
    // routing checks
    // ----------------------------------------
    a_route_zero: assert property (
        irq_out_a_select == 4'h0 |-> !irq_out_a)
        else $error("code zero output not low");
    a_route_preamble: assert property (
        irq_out_a_select == 4'h2 |-> irq_out_a == flags_q[4])
        else $error("code two does not follow preamble flag");
    a_route_direct: assert property (
        (data_mode == RXIRQ_MODE_DIRECT) && (irq_out_b_select > 4'h6) |-> !irq_out_b)
        else $error("unused direct code not low");
    a_route_strobe: assert property (
        buf_mode && (irq_out_b_select == 4'h9) |-> irq_out_b == queue_in.queue_byte_written_pulse)
        else $error("byte strobe not routed");
endmodule

// ==== rtl/rxirq_pkg.sv ====
package rxirq_pkg;
    // operating state as reported by the state controller
    typedef enum logic [2:0] {
        RXIRQ_ST_PUP = 3'b000,
        RXIRQ_ST_SLEEP = 3'b001,
        RXIRQ_ST_STBY = 3'b010,
        RXIRQ_ST_TUNE = 3'b011,
        RXIRQ_ST_RX = 3'b100,
        RXIRQ_ST_NVM = 3'b101
    } rxirq_opstate_e;

    // data handling mode
    typedef enum logic [1:0] {
        RXIRQ_MODE_DIRECT = 2'b00,
        RXIRQ_MODE_BUFFER = 2'b01,
        RXIRQ_MODE_PACKET = 2'b10
    } rxirq_mode_e;

    // one-cycle event pulses from the receive chain
    typedef struct packed {
        logic sleep_timeout;
        logic receive_timeout;
        logic strength_valid;
        logic preamble_pass;
        logic sync_pass;
        logic node_match;
        logic checksum_pass;
        logic packet_done;
    } rxirq_events_s;

    // per-event enables, same bit order as the event flags
    typedef struct packed {
        logic sleep_timeout_enable;
        logic receive_timeout_enable;
        logic strength_valid_enable;
        logic preamble_pass_enable;
        logic sync_pass_enable;
        logic node_match_enable;
        logic checksum_pass_enable;
        logic packet_done_enable;
    } rxirq_enables_s;

    // register write/read port
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [6:0] addr;
        logic [7:0] wdata;
    } rxirq_regreq_s;

    // fifo occupancy inputs from the queue
    typedef struct packed {
        logic queue_full;
        logic queue_overflow;
        logic queue_byte_written_pulse;
    } rxirq_queue_s;
endpackage

// ==== tb/rxirq_host_model.sv ====
// ----------------------------------------
// host side of the register port
// ----------------------------------------
module rxirq_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output var rxirq_pkg::rxirq_regreq_s reg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import rxirq_pkg::*;

    // idle bus, strobes low
    initial begin
        reg_req = '0;
    end

    // released lines are scrambled so stale values cannot pass
    task automatic release_bus();
        reg_req.wr_en = 1'b0;
        reg_req.rd_en = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask

    // one write, taken at the next edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_req.addr = a;
        reg_req.wdata = d;
        if (a == 7'h44) begin
            reg_req.wdata[1:0] = 2'b00;
        end
        reg_req.wr_en = 1'b1;
        @(posedge sys_clk);
        #2;
        release_bus();
    endtask

    // one read, data settled one edge after the request
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_req.addr = a;
        reg_req.rd_en = 1'b1;
        @(posedge sys_clk);
        #2;
        d = reg_rdata;
        release_bus();
    endtask
endmodule

// ==== tb/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rxirq_pkg::*;

    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    rxirq_regreq_s reg_req;
    logic [7:0] reg_rdata;
    rxirq_opstate_e op_state = RXIRQ_ST_STBY;
    rxirq_mode_e data_mode = RXIRQ_MODE_PACKET;
    logic fsk_demod = 1'b1;
    rxirq_events_s events = '0;
    rxirq_enables_s enables = '1;
    logic [3:0] sel_a = 4'h0;
    logic [3:0] sel_b = 4'h0;
    logic strength_indicator = 1'b0;
    rxirq_queue_s queue_in = '0;
    logic [5:0] queue_count = 6'h00;
    logic [5:0] queue_threshold = 6'h04;
    logic queue_flush;
    logic packet_handler_reset;
    logic irq_out_a;
    logic irq_out_b;
    int error_cnt = 0;
    int checks_done = 0;

    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    always #10 sys_clk = ~sys_clk;

    rxirq_flags #(.CNT_W(6)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .op_state(op_state), .data_mode(data_mode), .fsk_demod(fsk_demod),
        .events(events), .enables(enables), .irq_out_a_select(sel_a),
        .irq_out_b_select(sel_b), .strength_indicator(strength_indicator),
        .queue_in(queue_in), .queue_count(queue_count),
        .queue_threshold(queue_threshold), .queue_flush(queue_flush),
        .packet_handler_reset(packet_handler_reset), .irq_out_a(irq_out_a),
        .irq_out_b(irq_out_b)
    );

    rxirq_host_model i_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        chk($sformatf("reg %h", a), exp, d);
    endtask

    // one-cycle event pulse; flags land at the edge ending it
    task automatic pulse(input logic [7:0] ev);
        @(posedge sys_clk);
        #2;
        events = ev;
        @(posedge sys_clk);
        #2;
        events = '0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(7'h43, 8'h00);
        rd_chk(7'h42, 8'h00);
        rd_chk(7'h50, 8'h00);
    endtask

    // set all, then peel off one bit at a time
    task automatic t_set_clear();
        logic [7:0] exp;
        exp = 8'hff;
        pulse(8'hff);
        i_host.wr(7'h42, 8'h00);
        repeat (5) @(posedge sys_clk);
        rd_chk(7'h43, exp);
        for (int i = 7; i >= 0; i--) begin
            i_host.wr(7'h42, 8'h01 << i);
            exp[i] = 1'b0;
            rd_chk(7'h43, exp);
        end
    endtask

    // disabled sources and wrong modes stay quiet
    task automatic t_qualify();
        enables = '0;
        pulse(8'hff);
        rd_chk(7'h43, 8'h00);
        enables = '1;
        data_mode = RXIRQ_MODE_BUFFER;
        fsk_demod = 1'b0;
        pulse(8'hff);
        rd_chk(7'h43, 8'hd8);
        i_host.wr(7'h42, 8'hff);
        data_mode = RXIRQ_MODE_PACKET;
        fsk_demod = 1'b1;
    endtask

    // clears ignored while asleep; sleep holds flush and handler reset
    task automatic t_sleep();
        pulse(8'h01);
        op_state = RXIRQ_ST_SLEEP;
        i_host.wr(7'h42, 8'hff);
        chk("handler reset", 8'h01, {7'h00, packet_handler_reset});
        chk("sleep flush", 8'h01, {7'h00, queue_flush});
        op_state = RXIRQ_ST_STBY;
        repeat (2) @(posedge sys_clk);
        rd_chk(7'h43, 8'h01);
        chk("handler run", 8'h00, {7'h00, packet_handler_reset});
        i_host.wr(7'h42, 8'h01);
        rd_chk(7'h43, 8'h00);
    endtask

    // status bits follow the queue, none in direct mode
    task automatic t_fifo();
        queue_in.queue_full = 1'b1;
        queue_in.queue_overflow = 1'b1;
        queue_count = 6'h04;
        rd_chk(7'h44, 8'h78);
        queue_in = '0;
        queue_count = 6'h03;
        rd_chk(7'h44, 8'h20);
        queue_count = 6'h00;
        rd_chk(7'h44, 8'h00);
        data_mode = RXIRQ_MODE_DIRECT;
        queue_count = 6'h04;
        rd_chk(7'h44, 8'h00);
        data_mode = RXIRQ_MODE_BUFFER;
        rd_chk(7'h44, 8'h30);
        data_mode = RXIRQ_MODE_PACKET;
        queue_count = 6'h00;
    endtask

    // flush pulses once in an active state, never in power-up
    task automatic t_flush();
        i_host.wr(7'h44, 8'h04);
        chk("flush", 8'h01, {7'h00, queue_flush});
        @(posedge sys_clk);
        #2;
        chk("flush end", 8'h00, {7'h00, queue_flush});
        op_state = RXIRQ_ST_PUP;
        i_host.wr(7'h44, 8'h04);
        chk("pup flush", 8'h00, {7'h00, queue_flush});
        op_state = RXIRQ_ST_STBY;
    endtask

    // routing codes depend on the data mode
    task automatic t_route();
        sel_a = 4'h2;
        sel_b = 4'h4;
        pulse(8'h10);
        chk("out a", 8'h01, {7'h00, irq_out_a});
        chk("out b", 8'h00, {7'h00, irq_out_b});
        pulse(8'h04);
        chk("out b node", 8'h01, {7'h00, irq_out_b});
        i_host.wr(7'h42, 8'hff);
        data_mode = RXIRQ_MODE_BUFFER;
        sel_b = 4'h9;
        @(posedge sys_clk);
        #2;
        queue_in.queue_byte_written_pulse = 1'b1;
        strength_indicator = 1'b1;
        sel_a = 4'hb;
        #1;
        chk("byte strobe", 8'h01, {7'h00, irq_out_b});
        chk("buffer indicator", 8'h01, {7'h00, irq_out_a});
        @(posedge sys_clk);
        #2;
        data_mode = RXIRQ_MODE_DIRECT;
        sel_a = 4'h6;
        #1;
        chk("direct indicator", 8'h01, {7'h00, irq_out_a});
        chk("direct strobe", 8'h00, {7'h00, irq_out_b});
        @(posedge sys_clk);
        #2;
        queue_in.queue_byte_written_pulse = 1'b0;
        strength_indicator = 1'b0;
        data_mode = RXIRQ_MODE_PACKET;
        rd_chk(7'h43, 8'h00);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        #2;
        rstn = 1'b1;
        t_reset();
        t_set_clear();
        t_qualify();
        t_sleep();
        t_fifo();
        t_flush();
        t_route();
        complete_run();
    end

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end
endmodule
